/* File: verilog/cst_pkg.sv */
// constants and types shared by the common start/trip aggregator
// assumes a 32-bit Avalon-MM register bus with byte addresses
package cst_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_START_ASSIGN = 6'h04;
  localparam logic [5:0] OFS_TRIP_ASSIGN = 6'h08;
  localparam logic [5:0] OFS_COND = 6'h0C;
  localparam logic [5:0] OFS_START_CNT = 6'h10;
  localparam logic [5:0] OFS_TRIP_CNT = 6'h14;
  localparam logic [5:0] OFS_CNT_CLR = 6'h18;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h1C;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h20;
  localparam logic [5:0] OFS_RAW = 6'h24;

  // ==========================================================
  // control register layout
  localparam int unsigned CTRL_FORCE_LSB = 0;
  localparam int unsigned CTRL_STORE_ON_BIT = 2;
  localparam int unsigned CTRL_STORE_OFF_BIT = 3;
  localparam logic [1:0] CTRL_FORCE_RESET = 2'h0;
  localparam logic CTRL_STORE_ON_RESET = 1'b1;
  localparam logic CTRL_STORE_OFF_RESET = 1'b1;

  // ==========================================================
  // counter clear strobes
  localparam int unsigned CLR_START_BIT = 0;
  localparam int unsigned CLR_TRIP_BIT = 1;

  // ==========================================================
  // raw status layout
  localparam int unsigned RAW_STAGE_START_BIT = 0;
  localparam int unsigned RAW_STAGE_TRIP_BIT = 1;
  localparam int unsigned RAW_EXTRA_START_BIT = 2;
  localparam int unsigned RAW_EXTRA_TRIP_BIT = 3;

  // ==========================================================
  // event indices, also interrupt status bit positions
  localparam int unsigned EV_START_ON = 0;
  localparam int unsigned EV_START_OFF = 1;
  localparam int unsigned EV_TRIP_ON = 2;
  localparam int unsigned EV_TRIP_OFF = 3;
  localparam int unsigned EV_NUM = 4;
  localparam int unsigned IRQ_LOST_BIT = 4;
  localparam int unsigned IRQ_W = 5;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;

  // ==========================================================
  // enumerations
  typedef enum logic [1:0] {
    CST_FORCE_NORMAL = 2'h0,
    CST_FORCE_START = 2'h1,
    CST_FORCE_TRIP = 2'h2
  } cst_force_t;

  typedef enum logic [1:0] {
    CST_COND_NORMAL = 2'h0,
    CST_COND_START = 2'h1,
    CST_COND_TRIP = 2'h2
  } cst_cond_t;

endpackage : cst_pkg

/* File: verilog/cst_edge.sv */
// output flop of one common signal with its on/off edge strobes
// assumes the level input is the combinational next value
`timescale 1ns/1ps
module cst_edge (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in
  input wire logic lvl_d,
  // registered level and edges of the coming update
  output logic lvl_q,
  output logic rise,
  output logic fall
);

  // ==========================================================
  // output flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
    end
  end

  // ==========================================================
  // edges seen one cycle early so the stamp matches the change
  assign rise = lvl_d & ~lvl_q;
  assign fall = ~lvl_d & lvl_q;

endmodule : cst_edge

/* File: verilog/cst_top.sv */
// common start/trip aggregator with event, counter and interrupt logic
// assumes stage and extra inputs synchronous to clk, time_now free running
//
// Functional notes
// - common start is any active stage start; common trip any active stage trip.
// - assigned extra start inputs also drive the common start.
// - assigned extra trip inputs also drive the common trip.
// - force setting normal/start/trip, default normal, honoured only with forcing enabled.
// - general settings stay put across setting group changes.
// - read-only condition shows normal, start or trip from the common outputs.
// - the block has no blocking input; suppression belongs inside each stage.
// - on and off events per common output, mask picks which get stored.
// - every recorded event carries the time of its status change.
// - resettable counters count common start and common trip events.
// - common start and trip are plain outputs for relays and user logic.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
module cst_top #(
  parameter int unsigned NSTAGE = 16,
  parameter int unsigned NEXTRA = 8,
  parameter int unsigned TSW = 32,
  parameter int unsigned CNTW = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // protection stages
  input wire logic [NSTAGE-1:0] stage_active,
  input wire logic [NSTAGE-1:0] stage_start,
  input wire logic [NSTAGE-1:0] stage_trip,
  // extra user inputs
  input wire logic [NEXTRA-1:0] extra_in,
  // global forcing enable from the general menu
  input wire logic force_enable,
  // time base
  input wire logic [TSW-1:0] time_now,
  // common outputs
  output logic common_start,
  output logic common_trip,
  // event record port
  output logic evt_valid,
  output logic [1:0] evt_code,
  output logic [TSW-1:0] evt_stamp,
  // interrupt
  output logic irq
);

  // ==========================================================
  // declarations
  logic [1:0] force_q;
  logic store_on_q;
  logic store_off_q;
  logic [NEXTRA-1:0] start_assign_q;
  logic [NEXTRA-1:0] trip_assign_q;
  logic [CNTW-1:0] start_cnt_q;
  logic [CNTW-1:0] trip_cnt_q;
  logic [cst_pkg::IRQ_W-1:0] irq_stat_q;
  logic [cst_pkg::IRQ_W-1:0] irq_stat_d;
  logic [cst_pkg::IRQ_W-1:0] irq_mask_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_ack;
  logic stage_start_any;
  logic stage_trip_any;
  logic extra_start_any;
  logic extra_trip_any;
  logic force_start;
  logic force_trip;
  logic start_d;
  logic trip_d;
  logic start_rise;
  logic start_fall;
  logic trip_rise;
  logic trip_fall;
  logic [cst_pkg::EV_NUM-1:0] ev;
  logic [cst_pkg::EV_NUM-1:0] ev_store;
  logic [cst_pkg::EV_NUM-1:0] pend_q;
  logic [cst_pkg::EV_NUM-1:0] launch;
  logic [cst_pkg::EV_NUM-1:0] lost;
  logic [TSW-1:0] stamp_q [cst_pkg::EV_NUM];
  logic evt_valid_q;
  logic [1:0] evt_code_q;
  logic [TSW-1:0] evt_stamp_q;
  logic irq_q;
  cst_pkg::cst_cond_t cond;

  // ==========================================================
  // bus handshake
  // one wait cycle: data is prepared, then the request is acked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign wr_ack = avs_write && !wait_q;

  // ==========================================================
  // general settings
  // no setting-group input reaches these flops, so group changes leave them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      force_q <= cst_pkg::CTRL_FORCE_RESET;
      store_on_q <= cst_pkg::CTRL_STORE_ON_RESET;
      store_off_q <= cst_pkg::CTRL_STORE_OFF_RESET;
    end else if (wr_ack && avs_address == cst_pkg::OFS_CTRL) begin
      force_q <= avs_writedata[cst_pkg::CTRL_FORCE_LSB +: 2];
      store_on_q <= avs_writedata[cst_pkg::CTRL_STORE_ON_BIT];
      store_off_q <= avs_writedata[cst_pkg::CTRL_STORE_OFF_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_assign_q <= '0;
      trip_assign_q <= '0;
    end else if (wr_ack && avs_address == cst_pkg::OFS_START_ASSIGN) begin
      start_assign_q <= avs_writedata[NEXTRA-1:0];
    end else if (wr_ack && avs_address == cst_pkg::OFS_TRIP_ASSIGN) begin
      trip_assign_q <= avs_writedata[NEXTRA-1:0];
    end
  end

  // ==========================================================
  // aggregation
  // there is no blocking term here; stages gate their own outputs
  assign stage_start_any = |(stage_start & stage_active);
  assign stage_trip_any = |(stage_trip & stage_active);
  assign extra_start_any = |(extra_in & start_assign_q);
  assign extra_trip_any = |(extra_in & trip_assign_q);

  // code 3 is undefined and decodes as normal
  assign force_start = force_enable &&
    (force_q == cst_pkg::CST_FORCE_START);
  assign force_trip = force_enable &&
    (force_q == cst_pkg::CST_FORCE_TRIP);

  assign start_d = stage_start_any || extra_start_any || force_start;
  assign trip_d = stage_trip_any || extra_trip_any || force_trip;

  // ==========================================================
  // output flops and edges
  cst_edge u_start (
    .clk(clk),
    .rst_n(rst_n),
    .lvl_d(start_d),
    .lvl_q(common_start),
    .rise(start_rise),
    .fall(start_fall)
  );

  cst_edge u_trip (
    .clk(clk),
    .rst_n(rst_n),
    .lvl_d(trip_d),
    .lvl_q(common_trip),
    .rise(trip_rise),
    .fall(trip_fall)
  );

  // ==========================================================
  // condition indication
  always_comb begin
    if (common_trip) begin
      cond = cst_pkg::CST_COND_TRIP;
    end else if (common_start) begin
      cond = cst_pkg::CST_COND_START;
    end else begin
      cond = cst_pkg::CST_COND_NORMAL;
    end
  end

  // ==========================================================
  // event vector and storage mask
  always_comb begin
    ev = '0;
    ev[cst_pkg::EV_START_ON] = start_rise;
    ev[cst_pkg::EV_START_OFF] = start_fall;
    ev[cst_pkg::EV_TRIP_ON] = trip_rise;
    ev[cst_pkg::EV_TRIP_OFF] = trip_fall;
    ev_store = '0;
    ev_store[cst_pkg::EV_START_ON] = start_rise && store_on_q;
    ev_store[cst_pkg::EV_START_OFF] = start_fall && store_off_q;
    ev_store[cst_pkg::EV_TRIP_ON] = trip_rise && store_on_q;
    ev_store[cst_pkg::EV_TRIP_OFF] = trip_fall && store_off_q;
  end

  // ==========================================================
  // launch choice: lowest pending index goes out first
  always_comb begin
    logic found;
    found = 1'b0;
    launch = '0;
    for (int i = 0; i < cst_pkg::EV_NUM; i++) begin
      if (pend_q[i] && !found) begin
        launch[i] = 1'b1;
        found = 1'b1;
      end
    end
  end

  // ==========================================================
  // per-event pending slots
  // one slot per event kind: a second event of one kind that comes while
  // its slot still waits behind a lower index is dropped and flagged as lost
  genvar g;
  generate
    for (g = 0; g < cst_pkg::EV_NUM; g++) begin : g_slot
      assign lost[g] = ev_store[g] && pend_q[g] && !launch[g];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pend_q[g] <= 1'b0;
          stamp_q[g] <= '0;
        end else if (ev_store[g] && (!pend_q[g] || launch[g])) begin
          pend_q[g] <= 1'b1;
          stamp_q[g] <= time_now;
        end else if (launch[g]) begin
          pend_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // event record port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_valid_q <= 1'b0;
      evt_code_q <= 2'h0;
      evt_stamp_q <= '0;
    end else begin
      evt_valid_q <= |launch;
      for (int i = 0; i < cst_pkg::EV_NUM; i++) begin
        if (launch[i]) begin
          evt_code_q <= i[1:0];
          evt_stamp_q <= stamp_q[i];
        end
      end
    end
  end

  assign evt_valid = evt_valid_q;
  assign evt_code = evt_code_q;
  assign evt_stamp = evt_stamp_q;

  // ==========================================================
  // cumulative counters
  // saturate rather than wrap so a long history never reads as small
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_cnt_q <= '0;
    end else if (wr_ack && avs_address == cst_pkg::OFS_CNT_CLR &&
                 avs_writedata[cst_pkg::CLR_START_BIT]) begin
      start_cnt_q <= {{(CNTW-1){1'b0}}, start_rise};
    end else if (start_rise && start_cnt_q != {CNTW{1'b1}}) begin
      start_cnt_q <= start_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_cnt_q <= '0;
    end else if (wr_ack && avs_address == cst_pkg::OFS_CNT_CLR &&
                 avs_writedata[cst_pkg::CLR_TRIP_BIT]) begin
      trip_cnt_q <= {{(CNTW-1){1'b0}}, trip_rise};
    end else if (trip_rise && trip_cnt_q != {CNTW{1'b1}}) begin
      trip_cnt_q <= trip_cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // interrupt status, mask and output
  // a new event in the clearing cycle keeps its bit set
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr_ack && avs_address == cst_pkg::OFS_IRQ_STAT) begin
      irq_stat_d = irq_stat_q & ~avs_writedata[cst_pkg::IRQ_W-1:0];
    end
    irq_stat_d[cst_pkg::EV_NUM-1:0] = irq_stat_d[cst_pkg::EV_NUM-1:0] | ev;
    irq_stat_d[cst_pkg::IRQ_LOST_BIT] = irq_stat_d[cst_pkg::IRQ_LOST_BIT] | (|lost);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= cst_pkg::IRQ_MASK_RESET;
    end else if (wr_ack && avs_address == cst_pkg::OFS_IRQ_MASK) begin
      irq_mask_q <= avs_writedata[cst_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_d & irq_mask_q);
    end
  end

  assign irq = irq_q;

  // ==========================================================
  // read mux, unmapped offsets read as zero
  always_comb begin
    rdata_d = '0;
    if (avs_address == cst_pkg::OFS_CTRL) begin
      rdata_d[cst_pkg::CTRL_FORCE_LSB +: 2] = force_q;
      rdata_d[cst_pkg::CTRL_STORE_ON_BIT] = store_on_q;
      rdata_d[cst_pkg::CTRL_STORE_OFF_BIT] = store_off_q;
    end else if (avs_address == cst_pkg::OFS_START_ASSIGN) begin
      rdata_d[NEXTRA-1:0] = start_assign_q;
    end else if (avs_address == cst_pkg::OFS_TRIP_ASSIGN) begin
      rdata_d[NEXTRA-1:0] = trip_assign_q;
    end else if (avs_address == cst_pkg::OFS_COND) begin
      rdata_d[1:0] = cond;
    end else if (avs_address == cst_pkg::OFS_START_CNT) begin
      rdata_d[CNTW-1:0] = start_cnt_q;
    end else if (avs_address == cst_pkg::OFS_TRIP_CNT) begin
      rdata_d[CNTW-1:0] = trip_cnt_q;
    end else if (avs_address == cst_pkg::OFS_IRQ_STAT) begin
      rdata_d[cst_pkg::IRQ_W-1:0] = irq_stat_q;
    end else if (avs_address == cst_pkg::OFS_IRQ_MASK) begin
      rdata_d[cst_pkg::IRQ_W-1:0] = irq_mask_q;
    end else if (avs_address == cst_pkg::OFS_RAW) begin
      rdata_d[cst_pkg::RAW_STAGE_START_BIT] = stage_start_any;
      rdata_d[cst_pkg::RAW_STAGE_TRIP_BIT] = stage_trip_any;
      rdata_d[cst_pkg::RAW_EXTRA_START_BIT] = extra_start_any;
      rdata_d[cst_pkg::RAW_EXTRA_TRIP_BIT] = extra_trip_any;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (avs_read && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

endmodule : cst_top

/* File: dv/cst_monitor.sv */
// port checker for the common start/trip aggregator
// assumes it is bound onto cst_top and sees only its ports
`timescale 1ns/1ps
module cst_monitor #(
  parameter int unsigned NSTAGE = 16,
  parameter int unsigned NEXTRA = 8,
  parameter int unsigned TSW = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // inputs
  input wire logic [NSTAGE-1:0] stage_active,
  input wire logic [NSTAGE-1:0] stage_start,
  input wire logic [NSTAGE-1:0] stage_trip,
  input wire logic [NEXTRA-1:0] extra_in,
  input wire logic force_enable,
  input wire logic [TSW-1:0] time_now,
  // outputs
  input wire logic common_start,
  input wire logic common_trip,
  input wire logic evt_valid,
  input wire logic [1:0] evt_code,
  input wire logic [TSW-1:0] evt_stamp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ========
  // bus answer
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no bus answer");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer too long");
  // ========
  // common outputs
  property p_start;
    |(stage_active & stage_start) |=> common_start;
  endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_trip;
    |(stage_active & stage_trip) |=> common_trip;
  endproperty
  a_trip: assert property (p_trip) else $error("trip missed");
  // low only provable when no extra input at all is high
  property p_start_low;
    !force_enable && !(|(stage_active & stage_start)) && extra_in == '0 |=> !common_start;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start spurious");
  property p_trip_low;
    !force_enable && !(|(stage_active & stage_trip)) && extra_in == '0 |=> !common_trip;
  endproperty
  a_trip_low: assert property (p_trip_low) else $error("trip spurious");
  // ========
  // events
  property p_stamp_on;
    $rose(common_start) ##1 (evt_valid && evt_code == 2'h0) |-> evt_stamp == $past(time_now, 2);
  endproperty
  a_stamp_on: assert property (p_stamp_on) else $error("start stamp");
  property p_stamp_off;
    $fell(common_trip) ##1 (evt_valid && evt_code == 2'h3) |-> evt_stamp == $past(time_now, 2);
  endproperty
  a_stamp_off: assert property (p_stamp_off) else $error("trip stamp");
  // four slots drain in four cycles at most
  property p_quiet;
    ($stable(common_start) && $stable(common_trip)) [*4] |=> !evt_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("event without change");
endmodule : cst_monitor

bind cst_top cst_monitor #(.NSTAGE(NSTAGE), .NEXTRA(NEXTRA), .TSW(TSW)) cst_monitor_i (
  .clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .stage_active(stage_active),
  .stage_start(stage_start), .stage_trip(stage_trip), .extra_in(extra_in),
  .force_enable(force_enable), .time_now(time_now), .common_start(common_start),
  .common_trip(common_trip), .evt_valid(evt_valid), .evt_code(evt_code),
  .evt_stamp(evt_stamp)
);

/* File: dv/cst_far_model.sv */
// far side: protection stages, time base and event recorder
// assumes the bench sets stage levels through set_stages
`timescale 1ns/1ps
module cst_far_model #(
  parameter int unsigned NSTAGE = 16,
  parameter int unsigned TSW = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // stage levels
  output logic [NSTAGE-1:0] stage_active,
  output logic [NSTAGE-1:0] stage_start,
  output logic [NSTAGE-1:0] stage_trip,
  // time base
  output logic [TSW-1:0] time_now,
  // event record port
  input wire logic evt_valid,
  input wire logic [1:0] evt_code,
  input wire logic [TSW-1:0] evt_stamp
);
  logic [TSW+1:0] rec_q[$];
  initial begin
    stage_active = '0;
    stage_start = '0;
    stage_trip = '0;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) time_now <= '0;
    else time_now <= time_now + 1'b1;
  end
  // record sampled at the edge, as a real buffer would take it
  always @(posedge clk) begin
    if (rst_n === 1'b1 && evt_valid === 1'b1) rec_q.push_back({evt_code, evt_stamp});
  end
  task automatic set_stages(input logic [NSTAGE-1:0] a, s, t);
    stage_active <= a;
    stage_start <= s;
    stage_trip <= t;
  endtask : set_stages
endmodule : cst_far_model

/* File: dv/tb_cst_top.sv */
// self-checking bench for the common start/trip aggregator
// assumes cst_far_model drives stages and records events
`timescale 1ns/1ps
module tb_cst_top;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, force_enable, irq;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, time_now, evt_stamp;
  logic [15:0] stage_active, stage_start, stage_trip;
  logic [7:0] extra_in;
  logic common_start, common_trip, evt_valid;
  logic [1:0] evt_code;
  int mismatches, tests_run;
  cst_top cst_top_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .stage_active(stage_active), .stage_start(stage_start), .stage_trip(stage_trip),
    .extra_in(extra_in), .force_enable(force_enable), .time_now(time_now),
    .common_start(common_start), .common_trip(common_trip), .evt_valid(evt_valid),
    .evt_code(evt_code), .evt_stamp(evt_stamp), .irq(irq));
  cst_far_model cst_far_model_i (.clk(clk), .rst_n(rst_n), .stage_active(stage_active),
    .stage_start(stage_start), .stage_trip(stage_trip), .time_now(time_now),
    .evt_valid(evt_valid), .evt_code(evt_code), .evt_stamp(evt_stamp));
  always #2.5 clk = ~clk;
  // ========
  // helpers
  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(nm, e, q);
  endtask : rd_chk
  task automatic evt_chk(input string nm, input logic [1:0] c, input logic [31:0] s);
    logic [33:0] r;
    int n;
    n = 0;
    while (cst_far_model_i.rec_q.size() == 0 && n < 10) begin
      @(posedge clk);
      n++;
    end
    if (cst_far_model_i.rec_q.size() == 0) chk(nm, 32'h1, 32'h0);
    else begin
      r = cst_far_model_i.rec_q.pop_front();
      chk(nm, {30'h0, c}, {30'h0, r[33:32]});
      chk(nm, s, r[31:0]);
    end
  endtask : evt_chk
  // ========
  // scenarios
  task automatic t_reset();
    rd_chk("ctrl", cst_pkg::OFS_CTRL, 32'h0000000C);
    rd_chk("cond", cst_pkg::OFS_COND, 32'h0);
    rd_chk("start cnt", cst_pkg::OFS_START_CNT, 32'h0);
    wr(6'h3C, 32'hFFFFFFFF);
    rd_chk("unmapped", 6'h3C, 32'h0);
  endtask : t_reset
  task automatic t_stage();
    logic [31:0] st;
    cst_far_model_i.set_stages(16'h8001, 16'h0003, 16'h0000);
    #1 st = time_now;
    cyc(2);
    chk("start", 32'h1, {31'h0, common_start});
    evt_chk("start on", 2'h0, st);
    cst_far_model_i.set_stages(16'h8001, 16'h0002, 16'h8000);
    #1 st = time_now;
    cyc(2);
    chk("trip", 32'h1, {31'h0, common_trip});
    chk("start", 32'h0, {31'h0, common_start});
    evt_chk("start off", 2'h1, st);
    evt_chk("trip on", 2'h2, st);
    rd_chk("cond", cst_pkg::OFS_COND, 32'h2);
    cst_far_model_i.set_stages(16'h0000, 16'h0000, 16'h8000);
    #1 st = time_now;
    cyc(2);
    chk("trip", 32'h0, {31'h0, common_trip});
    evt_chk("trip off", 2'h3, st);
    rd_chk("start cnt", cst_pkg::OFS_START_CNT, 32'h1);
    rd_chk("trip cnt", cst_pkg::OFS_TRIP_CNT, 32'h1);
  endtask : t_stage
  task automatic t_extra();
    logic [7:0] xv[3] = '{8'h08, 8'h20, 8'hD7};
    wr(cst_pkg::OFS_START_ASSIGN, 32'h08);
    wr(cst_pkg::OFS_TRIP_ASSIGN, 32'h20);
    for (int i = 0; i < 3; i++) begin
      extra_in <= xv[i];
      cyc(2);
      chk("start", {31'h0, i == 0}, {31'h0, common_start});
      chk("trip", {31'h0, i == 1}, {31'h0, common_trip});
      rd_chk("raw", cst_pkg::OFS_RAW, {28'h0, i == 1, i == 0, 2'b00});
    end
    extra_in <= 8'h00;
  endtask : t_extra
  task automatic t_force();
    for (int e = 0; e < 2; e++) begin
      for (int f = 0; f < 4; f++) begin
        force_enable <= e[0];
        wr(cst_pkg::OFS_CTRL, {28'h0, 2'b11, f[1:0]});
        cyc(2);
        chk("start", {31'h0, e == 1 && f == 1}, {31'h0, common_start});
        chk("trip", {31'h0, e == 1 && f == 2}, {31'h0, common_trip});
        rd_chk("cond", cst_pkg::OFS_COND, (e == 1 && f < 3) ? 32'(f) : 32'h0);
      end
    end
    wr(cst_pkg::OFS_CTRL, 32'h0000000C);
    force_enable <= 1'b0;
  endtask : t_force
  task automatic t_mask();
    logic [31:0] st;
    cyc(6);
    cst_far_model_i.rec_q.delete();
    wr(cst_pkg::OFS_IRQ_STAT, 32'h1F);
    wr(cst_pkg::OFS_CNT_CLR, 32'h3);
    rd_chk("start cnt", cst_pkg::OFS_START_CNT, 32'h0);
    wr(cst_pkg::OFS_CTRL, 32'h04);
    wr(cst_pkg::OFS_IRQ_MASK, 32'h01);
    cst_far_model_i.set_stages(16'h0001, 16'h0001, 16'h0000);
    #1 st = time_now;
    cyc(2);
    chk("irq", 32'h1, {31'h0, irq});
    evt_chk("start on", 2'h0, st);
    cst_far_model_i.set_stages(16'h0000, 16'h0000, 16'h0000);
    cyc(6);
    chk("off stored", 32'h0, cst_far_model_i.rec_q.size());
    rd_chk("irq stat", cst_pkg::OFS_IRQ_STAT, 32'h03);
    wr(cst_pkg::OFS_IRQ_STAT, 32'h01);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq});
    rd_chk("start cnt", cst_pkg::OFS_START_CNT, 32'h1);
    rd_chk("ctrl kept", cst_pkg::OFS_CTRL, 32'h04);
  endtask : t_mask
  // ========
  // main
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    extra_in = 8'h00;
    force_enable = 1'b0;
    mismatches = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_stage();
    t_extra();
    t_force();
    t_mask();
    stop_test();
  end
  // all scenarios take well under 2000 cycles
  initial begin
    #50000;
    mismatches++;
    $display("wrong value %s expected %s seen %s", "watchdog", "done", "timeout");
    stop_test();
  end
endmodule : tb_cst_top
